// ===== data_move_instruction_decode_tb.sv
// self-checking testbench of the data-move decoder against a memory model
`timescale 1ns/10ps
`default_nettype none
module data_move_instruction_decode_tb;
    import dmd_pkg::*;
    logic        sys_clk, rstn, insnValid, fetchBusy, insnReady, memReq, memWrite, memAck;
    logic        statusT, setT, setTValue, moveDone, lastWrite;
    logic [15:0] insnCode;
    logic [1:0]  memSize, lastSize, sz;
    logic [2:0]  waitLen;
    logic [3:0]  m, n, d;
    logic [31:0] insnPc, memAddr, memWdata, memRdata, reg0View, lastAddr, lastWdata, v, a0, ad;
    int          miscompares = 0;
    int          checkCount = 0;
    int          seed = 29973;
    int          cycles = 0;

    dmd_move_decode dut (.sys_clk(sys_clk), .rstn(rstn), .insnValid(insnValid), .insnCode(insnCode),
        .insnPc(insnPc), .fetchBusy(fetchBusy), .insnReady(insnReady), .memReq(memReq), .memWrite(memWrite),
        .memSize(memSize), .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata),
        .statusT(statusT), .setT(setT), .setTValue(setTValue), .moveDone(moveDone), .reg0View(reg0View));
    dmd_mem_model mem (.sys_clk(sys_clk), .rstn(rstn), .memReq(memReq), .memWrite(memWrite), .memSize(memSize),
        .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata), .waitLen(waitLen),
        .lastAddr(lastAddr), .lastWdata(lastWdata), .lastSize(lastSize), .lastWrite(lastWrite));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic tallyAndFinish();
        if (miscompares == 0 && checkCount > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tallyAndFinish

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            tallyAndFinish();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [31:0] sext(input logic [31:0] x, input logic [1:0] s);
        return (s == 2'h0) ? {{24{x[7]}}, x[7:0]} : (s == 2'h1) ? {{16{x[15]}}, x[15:0]} : x;
    endfunction : sext

    function automatic logic [31:0] pat(input logic [31:0] a);
        return {a[7:0] ^ 8'h5a, a[7:0], ~a[7:0], a[7:0] | 8'h80};
    endfunction : pat

    function automatic logic [31:0] msk(input logic [1:0] s);
        return (s == 2'h0) ? 32'h0000_00ff : (s == 2'h1) ? 32'h0000_ffff : 32'hffff_ffff;
    endfunction : msk

    // offer one instruction, hold it until taken, then wait for completion
    task automatic run(input logic [15:0] code, input int lim);
        int k;
        insnCode  = code;
        insnValid = 1'b1;
        k = 0;
        #1;
        while (insnReady !== 1'b1 && k < 50) begin
            @(negedge sys_clk);
            k++;
        end
        @(negedge sys_clk);
        insnValid = 1'b0;
        k = 0;
        while (moveDone !== 1'b1 && k < 50) begin
            @(negedge sys_clk);
            k++;
        end
        check(32'(k <= lim), 32'h1);
        @(negedge sys_clk);
    endtask : run

    task automatic setReg(input logic [3:0] r, input logic [7:0] imm);
        run({4'he, r, imm}, 1);
    endtask : setReg

    task automatic expReg(input logic [3:0] r, input logic [31:0] exp);
        run({4'h6, 4'h0, r, 4'h3}, 1);
        check(reg0View, exp);
    endtask : expReg

    task automatic expMem(input logic [31:0] a, input logic w, input logic [1:0] s, input logic [31:0] dat);
        check(lastAddr, a);
        check(32'(lastWrite), 32'(w));
        check(32'(lastSize), 32'(s));
        if (w) check(lastWdata & msk(s), dat & msk(s));
    endtask : expMem

    initial begin
        {rstn, insnValid, fetchBusy, setT, setTValue} = 5'h0;
        insnCode = 16'h0;
        insnPc   = 32'h0;
        waitLen  = 3'h0;
        repeat (16) @(negedge sys_clk);
        rstn = 1'b1;
        @(negedge sys_clk);
        setT      = 1'b1;
        setTValue = 1'b1;
        @(negedge sys_clk);
        setT = 1'b0;
        for (int i = 0; i < 16; i++) begin
            v = $random(seed);
            if (i == 15) v[7:0] = 8'h80;
            setReg(4'(i), v[7:0]);
            expReg(4'(i), sext(v, 2'h0));
        end
        for (int k = 0; k < 12; k++) begin
            sz      = 2'(k % 3);
            v       = $random(seed);
            waitLen = v[10:8];
            d       = v[15:12];
            m       = 4'h1 + {1'b0, v[18:16]};
            n       = 4'h9 + {2'b0, v[21:20]};
            a0      = sext(v, 2'h0);
            ad      = a0 + ({28'h0, d} << sz);
            setReg(m, v[7:0]);
            run({4'h6, n, m, 2'b00, sz}, waitLen + 3);
            expMem(a0, 1'b0, sz, 32'h0);
            expReg(n, sext(pat(a0), sz));
            setReg(m, v[7:0]);
            run({4'h6, n, m, 2'b01, sz}, waitLen + 3);
            expMem(a0, 1'b0, sz, 32'h0);
            expReg(n, sext(pat(a0), sz));
            expReg(m, a0 + (32'h1 << sz));
            setReg(n, v[7:0]);
            setReg(m, v[31:24]);
            run({4'h2, n, m, 2'b01, sz}, waitLen + 3);
            expMem(a0 - (32'h1 << sz), 1'b1, sz, sext({24'h0, v[31:24]}, 2'h0));
            expReg(n, a0 - (32'h1 << sz));
            run({4'h2, m, n, 2'b00, sz}, waitLen + 3);
            expMem(sext({24'h0, v[31:24]}, 2'h0), 1'b1, sz, a0 - (32'h1 << sz));
            insnPc = $random(seed);
            if (sz != 2'h0) begin
                run({(sz == 2'h1) ? 4'h9 : 4'hd, n, v[7:0]}, waitLen + 3);
                expMem(insnPc + ({24'h0, v[7:0]} << sz), 1'b0, sz, 32'h0);
                expReg(n, sext(pat(insnPc + ({24'h0, v[7:0]} << sz)), sz));
            end
            if (sz != 2'h2) begin
                setReg(4'h0, v[31:24]);
                setReg(n, v[7:0]);
                run({7'h40, sz[0], n, d}, waitLen + 3);
                expMem(ad, 1'b1, sz, sext({24'h0, v[31:24]}, 2'h0));
                setReg(m, v[7:0]);
                run({7'h42, sz[0], m, d}, waitLen + 3);
                expMem(ad, 1'b0, sz, 32'h0);
                check(reg0View, sext(pat(ad), sz));
                setReg(4'h0, v[31:24]);
                setReg(n, v[7:0]);
                setReg(m, v[23:16]);
                run({4'h0, n, m, 2'b01, sz}, waitLen + 3);
                expMem(sext({24'h0, v[31:24]}, 2'h0) + a0, 1'b1, sz, sext({24'h0, v[23:16]}, 2'h0));
            end else begin
                setReg(n, v[7:0]);
                setReg(m, v[31:24]);
                run({4'h1, n, m, d}, waitLen + 3);
                expMem(ad, 1'b1, 2'h2, sext({24'h0, v[31:24]}, 2'h0));
                setReg(m, v[7:0]);
                run({4'h5, n, m, d}, waitLen + 3);
                expMem(ad, 1'b0, 2'h2, 32'h0);
                expReg(n, pat(ad));
            end
        end
        fetchBusy = 1'b1;
        insnCode  = 16'h6003;
        insnValid = 1'b1;
        repeat (3) @(negedge sys_clk);
        check(32'(insnReady), 32'h0);
        fetchBusy = 1'b0;
        run(16'h6003, 1);
        waitLen = 3'h3;
        setReg(4'h1, 8'h10);
        insnCode  = 16'h6212;
        insnValid = 1'b1;
        @(negedge sys_clk);
        insnCode = 16'h6023;
        #1;
        check(32'(insnReady), 32'h0);
        @(negedge sys_clk);
        // keep the dependent move offered so it is taken only once the load lands
        run(16'h6023, 8);
        check(reg0View, pat(32'h10));
        expReg(4'h2, pat(32'h10));
        check(32'(statusT), 32'h1);
        tallyAndFinish();
    end
endmodule : data_move_instruction_decode_tb
`default_nettype wire

// ===== dmd_mem_model.sv
// data memory model answering the decoder's access port with a set wait length
`timescale 1ns/10ps
`default_nettype none
module dmd_mem_model (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // access port from the decoder
    input  wire logic        memReq,
    input  wire logic        memWrite,
    input  wire logic [1:0]  memSize,
    input  wire logic [31:0] memAddr,
    input  wire logic [31:0] memWdata,
    output logic             memAck,
    output logic [31:0]      memRdata,
    // wait length and record of the last access
    input  wire logic [2:0]  waitLen,
    output logic [31:0]      lastAddr,
    output logic [31:0]      lastWdata,
    output logic [1:0]       lastSize,
    output logic             lastWrite
);
    logic [2:0] waitCnt;
    logic       guard;

    // read data is a pattern of the address; between acks the bus toggles
    always @(negedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            memAck    <= 1'b0;
            memRdata  <= 32'h0;
            waitCnt   <= 3'h0;
            guard     <= 1'b0;
            lastAddr  <= 32'h0;
            lastWdata <= 32'h0;
            lastSize  <= 2'h0;
            lastWrite <= 1'b0;
        end else begin
            memAck   <= 1'b0;
            memRdata <= ~memRdata;
            guard    <= memAck;
            if (memReq && !memAck && !guard) begin
                if (waitCnt >= waitLen) begin
                    memAck    <= 1'b1;
                    waitCnt   <= 3'h0;
                    lastAddr  <= memAddr;
                    lastWdata <= memWdata;
                    lastSize  <= memSize;
                    lastWrite <= memWrite;
                    if (!memWrite) begin
                        memRdata <= {memAddr[7:0] ^ 8'h5a, memAddr[7:0], ~memAddr[7:0], memAddr[7:0] | 8'h80};
                    end
                end else begin
                    waitCnt <= waitCnt + 3'h1;
                end
            end
        end
    end
endmodule : dmd_mem_model
`default_nettype wire

// ===== dmd_move_decode.sv
// decode and execution of the data-move instructions with register file
`timescale 1ns/10ps
`default_nettype none
module dmd_move_decode
    import dmd_pkg::*;
#(
    parameter int DW = 32
) (
    // clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rstn,
    // instruction fetch side
    input  wire logic          insnValid,
    input  wire logic [15:0]   insnCode,
    input  wire logic [DW-1:0] insnPc,
    input  wire logic          fetchBusy,
    output logic               insnReady,
    // data memory side
    output logic               memReq,
    output logic               memWrite,
    output logic [1:0]         memSize,
    output logic [DW-1:0]      memAddr,
    output logic [DW-1:0]      memWdata,
    input  wire logic          memAck,
    input  wire logic [DW-1:0] memRdata,
    // status and debug view
    output logic               statusT,
    input  wire logic          setT,
    input  wire logic          setTValue,
    output logic               moveDone,
    output logic [DW-1:0]      reg0View
);
    logic [DW-1:0] gpr_r [16];
    logic [DW-1:0] statusReg_r;
    dmd_state_t    state_r;

    // latched memory operation
    logic          pendLoad_r;
    logic [3:0]    pendDst_r;
    dmd_size_t     pendSize_r;
    logic          pendSext_r;
    logic          done_r;

    function automatic logic [DW-1:0] sizeScale(input dmd_size_t sz, input logic [7:0] d);
        logic [DW-1:0] z;
        z = DW'(d);
        case (sz)
            SZ_BYTE: sizeScale = z;
            SZ_WORD: sizeScale = z << 1;
            default: sizeScale = z << 2;
        endcase
    endfunction : sizeScale

    function automatic logic [DW-1:0] extendData(input dmd_size_t sz, input logic sx,
                                                 input logic [DW-1:0] v);
        case (sz)
            SZ_BYTE: extendData = sx ? {{(DW-8){v[7]}}, v[7:0]} : DW'(v[7:0]);
            SZ_WORD: extendData = sx ? {{(DW-16){v[15]}}, v[15:0]} : DW'(v[15:0]);
            default: extendData = v;
        endcase
    endfunction : extendData

    // field decode
    logic [3:0]    op;
    logic [3:0]    rn;
    logic [3:0]    rm;
    logic [3:0]    lo;
    assign op = insnCode[15:12];
    assign rn = insnCode[11:8];
    assign rm = insnCode[7:4];
    assign lo = insnCode[3:0];

    // decoded action
    logic          isMove;
    logic          isMem;
    logic          isWrite;
    logic          sext;
    dmd_size_t     sz;
    logic [DW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          regWr;
    logic [3:0]    regIdx;
    logic [DW-1:0] regVal;
    logic          updWr;
    logic [3:0]    updIdx;
    logic [DW-1:0] updVal;
    logic [3:0]    ldDst;
    logic [3:0]    srcA;
    logic [3:0]    srcB;
    logic          usesA;
    logic          usesB;

    always_comb begin
        isMove  = 1'b0;
        isMem   = 1'b0;
        isWrite = 1'b0;
        sext    = 1'b0;
        sz      = SZ_LONG;
        addr    = '0;
        wdata   = '0;
        regWr   = 1'b0;
        regIdx  = rn;
        regVal  = '0;
        updWr   = 1'b0;
        updIdx  = rn;
        updVal  = '0;
        ldDst   = rn;
        srcA    = rm;
        srcB    = rn;
        usesA   = 1'b0;
        usesB   = 1'b0;
        case (op)
            OPC_IMM: begin
                isMove = 1'b1;
                regWr  = 1'b1;
                regVal = {{(DW-8){insnCode[7]}}, insnCode[7:0]};
            end
            OPC_PCW: begin
                isMove = 1'b1;
                isMem  = 1'b1;
                sz     = SZ_WORD;
                sext   = 1'b1;
                addr   = insnPc + sizeScale(SZ_WORD, insnCode[7:0]);
            end
            OPC_PCL: begin
                isMove = 1'b1;
                isMem  = 1'b1;
                addr   = insnPc + sizeScale(SZ_LONG, insnCode[7:0]);
            end
            OPC_DSTL: begin
                isMove  = 1'b1;
                isMem   = 1'b1;
                isWrite = 1'b1;
                usesA   = 1'b1;
                usesB   = 1'b1;
                addr    = gpr_r[rn] + sizeScale(SZ_LONG, {4'h0, lo});
                wdata   = gpr_r[rm];
            end
            OPC_DLDL: begin
                isMove = 1'b1;
                isMem  = 1'b1;
                usesA  = 1'b1;
                addr   = gpr_r[rm] + sizeScale(SZ_LONG, {4'h0, lo});
            end
            OPC_GRP8: begin
                sz    = dmd_size_t'({1'b0, rn[0]});
                usesA = 1'b1;
                srcA  = rm;
                if (rn == SUB_8_STB || rn == SUB_8_STW) begin
                    isMove  = 1'b1;
                    isMem   = 1'b1;
                    isWrite = 1'b1;
                    usesB   = 1'b1;
                    srcB    = 4'h0;
                    addr    = gpr_r[rm] + sizeScale(sz, {4'h0, lo});
                    wdata   = gpr_r[0];
                end else if (rn == SUB_8_LDB || rn == SUB_8_LDW) begin
                    isMove = 1'b1;
                    isMem  = 1'b1;
                    sext   = 1'b1;
                    ldDst  = 4'h0;
                    addr   = gpr_r[rm] + sizeScale(sz, {4'h0, lo});
                end
            end
            OPC_GRP2: begin
                sz    = dmd_size_t'(lo[1:0]);
                usesA = 1'b1;
                usesB = 1'b1;
                wdata = gpr_r[rm];
                if (lo[3:2] == 2'h0 && lo[1:0] != 2'h3) begin
                    isMove  = 1'b1;
                    isMem   = 1'b1;
                    isWrite = 1'b1;
                    addr    = gpr_r[rn];
                end else if (lo[3:2] == 2'h1 && lo[1:0] != 2'h3) begin
                    isMove  = 1'b1;
                    isMem   = 1'b1;
                    isWrite = 1'b1;
                    updVal  = gpr_r[rn] - sizeScale(sz, 8'h01);
                    updWr   = 1'b1;
                    addr    = updVal;
                end
            end
            OPC_GRP6: begin
                sz    = dmd_size_t'(lo[1:0]);
                usesA = 1'b1;
                if (lo == SUB_MOVRR) begin
                    isMove = 1'b1;
                    regWr  = 1'b1;
                    regVal = gpr_r[rm];
                end else if (lo[3] == 1'b0 && lo[1:0] != 2'h3) begin
                    isMove = 1'b1;
                    isMem  = 1'b1;
                    sext   = 1'b1;
                    addr   = gpr_r[rm];
                    if (lo[2]) begin
                        updWr  = 1'b1;
                        updIdx = rm;
                        updVal = gpr_r[rm] + sizeScale(sz, 8'h01);
                    end
                end
            end
            OPC_GRP0: begin
                sz    = dmd_size_t'(lo[1:0]);
                usesA = 1'b1;
                usesB = 1'b1;
                srcB  = 4'h0;
                if (lo[3:2] == 2'h1 && lo[1:0] != 2'h3) begin
                    isMove  = 1'b1;
                    isMem   = 1'b1;
                    isWrite = 1'b1;
                    addr    = gpr_r[0] + gpr_r[rn];
                    wdata   = gpr_r[rm];
                end
            end
            default: isMove = 1'b0;
        endcase
    end

    // load-use hazard against the load still in flight
    logic hazard;
    assign hazard = pendLoad_r && ((usesA && srcA == pendDst_r) || (usesB && srcB == pendDst_r) ||
                    (op == OPC_GRP2 && rn == pendDst_r) || (op == OPC_GRP8 && pendDst_r == 4'h0));

    // stall when fetch contends, a hazard exists, or memory has not answered
    assign insnReady = (state_r == ST_IDLE) && !fetchBusy && !hazard;
    logic take;
    assign take = insnValid && insnReady && isMove;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_r    <= ST_IDLE;
            pendLoad_r <= 1'b0;
            pendDst_r  <= 4'h0;
            pendSize_r <= SZ_LONG;
            pendSext_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (take && isMem) begin
                        state_r    <= ST_WAIT;
                        pendLoad_r <= !isWrite;
                        pendDst_r  <= ldDst;
                        pendSize_r <= sz;
                        pendSext_r <= sext;
                    end
                end
                ST_WAIT: begin
                    if (memAck) begin
                        state_r    <= ST_IDLE;
                        pendLoad_r <= 1'b0;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // memory request held until acknowledge
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            memReq   <= 1'b0;
            memWrite <= 1'b0;
            memSize  <= 2'h0;
            memAddr  <= REG_RESET;
            memWdata <= REG_RESET;
        end else if (take && isMem) begin
            memReq   <= 1'b1;
            memWrite <= isWrite;
            memSize  <= sz;
            memAddr  <= addr;
            memWdata <= wdata;
        end else if (memAck) begin
            memReq <= 1'b0;
        end
    end

    // register file writes; move result, base update and load result
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 16; i++) begin
                gpr_r[i] <= REG_RESET;
            end
        end else begin
            if (take && updWr) begin
                gpr_r[updIdx] <= updVal;
            end
            if (take && regWr) begin
                gpr_r[regIdx] <= regVal;
            end
            if (state_r == ST_WAIT && memAck && pendLoad_r) begin
                gpr_r[pendDst_r] <= extendData(pendSize_r, pendSext_r, memRdata);
            end
        end
    end

    // T flag changed only by the outside control path
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            statusReg_r <= SR_RESET;
        end else if (setT) begin
            statusReg_r[T_BIT] <= setTValue;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            done_r <= 1'b0;
        end else begin
            done_r <= (take && !isMem) || (state_r == ST_WAIT && memAck);
        end
    end

    assign statusT  = statusReg_r[T_BIT];
    assign moveDone = done_r;
    assign reg0View = gpr_r[0];

    t_kept_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (take && !setT) |=> $stable(statusT)) else $error("move changed T flag");
    one_cycle_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (take && !isMem) |=> moveDone) else $error("register move not done in one cycle");
    fetch_stall_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        fetchBusy |-> !insnReady) else $error("ready during fetch contention");
    load_use_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (pendLoad_r && usesA && srcA == pendDst_r) |-> !insnReady) else $error("load-use not stalled");
    imm_sext_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (take && op == OPC_IMM && rn == 4'h0) |=> reg0View == {{(DW-8){$past(insnCode[7])}}, $past(insnCode[7:0])})
        else $error("immediate not sign-extended");
    pcw_addr_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (take && op == OPC_PCW) |=> memAddr == $past(insnPc) + DW'({$past(insnCode[7:0]), 1'b0}))
        else $error("word PC-relative address wrong");
    pcl_addr_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (take && op == OPC_PCL) |=> memAddr == $past(insnPc) + DW'({$past(insnCode[7:0]), 2'b00}))
        else $error("long PC-relative address wrong");
    disp_store_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (take && op == OPC_GRP8 && rn == SUB_8_STB) |=> memWrite && memWdata == $past(reg0View))
        else $error("displacement store data not register zero");
    wait_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (memReq && !memAck) |=> memReq && $stable(memAddr)) else $error("request dropped before ack");

    store_c: cover property (@(posedge sys_clk) disable iff (!rstn) take && isMem && isWrite);
    load_c: cover property (@(posedge sys_clk) disable iff (!rstn) take && isMem && !isWrite);
    hazard_c: cover property (@(posedge sys_clk) disable iff (!rstn) insnValid && hazard);
endmodule : dmd_move_decode
`default_nettype wire

// ===== dmd_pkg.sv
// package of encodings and constants for the data-move instruction decoder
// Notes on behaviour
// - register fields are plain 4-bit indices, 0000 is register 0, 1111 is 15
// - displacement scaled by 1, 2 or 4 for byte, word, longword
// - register moves finish in one cycle, memory moves in two, when memory inserts no waits
// - fetch and data access contending stretches execution by extra cycles
// - next instruction using a register being loaded stalls until data arrives
// - moves never alter the T flag of the status register
// - immediate move sign-extends 8-bit immediate into destination
// - PC-relative word load at PC plus disp times two, sign-extended
// - PC-relative longword load at PC plus disp times four, unchanged
// - register-indirect loads sign-extend byte and word, longword unchanged
// - pre-decrement store lowers address register by size, then stores
// - post-increment load reads, sign-extends, then raises register by size
// - byte and word displacement stores take data from register zero
// - longword displacement store writes source at base plus disp times four
// - byte and word displacement loads sign-extend into register zero
// - indexed stores address register zero plus destination register
package dmd_pkg;
    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_WORD = 2'h1,
        SZ_LONG = 2'h2
    } dmd_size_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_WAIT  = 2'h1
    } dmd_state_t;

    localparam logic [3:0] OPC_IMM     = 4'he;
    localparam logic [3:0] OPC_PCW     = 4'h9;
    localparam logic [3:0] OPC_PCL     = 4'hd;
    localparam logic [3:0] OPC_GRP6    = 4'h6;
    localparam logic [3:0] OPC_GRP2    = 4'h2;
    localparam logic [3:0] OPC_GRP8    = 4'h8;
    localparam logic [3:0] OPC_DSTL    = 4'h1;
    localparam logic [3:0] OPC_DLDL    = 4'h5;
    localparam logic [3:0] OPC_GRP0    = 4'h0;
    localparam logic [3:0] SUB_MOVRR   = 4'h3;
    localparam logic [3:0] SUB_8_STB   = 4'h0;
    localparam logic [3:0] SUB_8_STW   = 4'h1;
    localparam logic [3:0] SUB_8_LDB   = 4'h4;
    localparam logic [3:0] SUB_8_LDW   = 4'h5;
    localparam int         T_BIT       = 0;
    localparam logic [31:0] REG_RESET  = 32'h0000_0000;
    localparam logic [31:0] SR_RESET   = 32'h0000_0000;
endpackage : dmd_pkg
